/* File: verification/mbpp_pad_model.sv */
`timescale 1ns/10ps

// Pads and far side: resolves each pin level from all drivers.
module mbpp_pad_model
(
   // Clock.
   input wire logic pclk,
   // Port side of the pads.
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pullup_en,
   output logic [7:0] pin_in,
   // Outside driver.
   input wire logic [7:0] ext_val,
   input wire logic ext_en
);
   logic [7:0] last = 8'h00;

   // A floating pin shows the inverse of its last level, so a stale value never passes.
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else if (ext_en) pin_in[i] = ext_val[i];
         else if (pullup_en[i]) pin_in[i] = 1'b1;
         else pin_in[i] = ~last[i];
      end
   end

   // Remembers the last level for floating pins.
   always_ff @(posedge pclk) last <= pin_in;
endmodule

/* File: verification/mbpp_port_assertions.sv */
`timescale 1ns/10ps

// Watches pin steering and bus answers of the port from its ports alone.
module mbpp_port_assertions
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pslverr,
   // Pins and owners.
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pullup_en,
   input wire logic [7:0] ttl_select,
   input wire logic [7:0] muxed_addr_data_low,
   input wire logic memory_bus_drive,
   input wire logic [7:0] memory_bus_read_data,
   input wire logic memory_bus_enabled,
   input wire logic parallel_port_active,
   input wire logic parallel_port_drive
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Pins follow their owner one edge after the cause; the pull-up, reset and slave error checks hold on the same edge.
   a_mem_drives_pins: assert property (
      memory_bus_enabled && memory_bus_drive |=>
      pin_oe_n == 8'h00 && pin_out == $past(muxed_addr_data_low)) else $error("memory drive");
   a_mem_read_ttl: assert property (
      memory_bus_enabled && !memory_bus_drive |=>
      ttl_select == 8'hFF && memory_bus_read_data == $past(pin_in)) else $error("memory read");
   a_mem_beats_par: assert property (
      memory_bus_enabled && !memory_bus_drive && parallel_port_active && parallel_port_drive
      |=> pin_oe_n == 8'hFF) else $error("memory priority");
   a_port_schmitt: assert property (
      !memory_bus_enabled && !parallel_port_active |=> ttl_select == 8'h00) else $error("threshold");
   a_pullup_not_out: assert property (
      (pullup_en & ~pin_oe_n) == 8'h00) else $error("pull-up on output");
   a_reset_inputs: assert property (
      disable iff (1'b0) !presetn |-> pin_oe_n == 8'hFF && pullup_en == 8'h00)
      else $error("reset pins");
   a_release_inputs: assert property (
      $rose(presetn) |-> pin_oe_n == 8'hFF ##1 pin_oe_n == 8'hFF) else $error("release pins");
   a_unmapped_err: assert property (
      psel && penable |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h14))
      else $error("slave error");
endmodule

/* File: verification/test_muxed_byte_port_pins.sv */
`timescale 1ns/10ps

// Drives the port over the bus and the pin side and compares with expected values.
module test_muxed_byte_port_pins;
   localparam logic [7:0] A_PIN = mbpp_pkg::PIN_STATE_OFFSET;
   localparam logic [7:0] A_LAT = mbpp_pkg::OUTPUT_LATCH_OFFSET;
   localparam logic [7:0] A_DIR = mbpp_pkg::DIRECTION_OFFSET;
   localparam logic [7:0] A_MEM = mbpp_pkg::MEMORY_BUS_CONTROL_OFFSET;
   localparam logic [7:0] A_NBR = mbpp_pkg::NEIGHBOUR_PORT_OFFSET;
   localparam logic [7:0] A_CFG = mbpp_pkg::PARALLEL_CONFIG_OFFSET;
   logic pclk = 1'b0;
   logic presetn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] pin_in;
   logic [7:0] pin_out;
   logic [7:0] pin_oe_n;
   logic [7:0] pullup_en;
   logic [7:0] ttl_select;
   logic [7:0] muxed = 8'h00;
   logic mbd = 1'b0;
   logic [7:0] mem_rd;
   logic mem_en;
   logic ppa = 1'b0;
   logic ppd = 1'b0;
   logic [7:0] ppdo = 8'h00;
   logic [7:0] pp_in;
   logic [7:0] ext_val = 8'hA3;
   logic ext_en = 1'b1;
   logic [31:0] rd;
   logic err;
   int num_errors = 0;
   int n_tests = 0;

   mbpp_port i_mbpp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .ttl_select(ttl_select),
      .muxed_addr_data_low(muxed), .memory_bus_drive(mbd), .memory_bus_read_data(mem_rd),
      .memory_bus_enabled(mem_en), .parallel_port_active(ppa), .parallel_port_drive(ppd),
      .parallel_port_data_out(ppdo), .parallel_port_data_in(pp_in));
   mbpp_pad_model i_mbpp_pad_model (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pullup_en(pullup_en), .pin_in(pin_in), .ext_val(ext_val), .ext_en(ext_en));

   // Half period of the 4 ns clock.
   always #2 pclk = ~pclk;

   // One bus transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   task automatic pchk(input string n, input logic [7:0] e, input logic [7:0] g);
      chk(n, {24'h000000, e}, {24'h000000, g});
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string n);
      apb(1'b0, a, 8'h00);
      chk(n, {24'h000000, e}, rd);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence.
   // Reset is asserted by a real falling edge so the asynchronous flops clear at once.
   initial
   begin
      presetn <= 1'b0;
      step(15);
      pchk("oe_rst", 8'hFF, pin_oe_n);
      pchk("pu_rst", 8'h00, pullup_en);
      @(posedge pclk);
      presetn <= 1'b1;
      rdchk(A_LAT, 8'h00, "lat_rst");
      rdchk(A_DIR, 8'hFF, "dir_rst");
      rdchk(A_MEM, 8'h80, "mem_rst");
      rdchk(A_NBR, 8'h00, "nbr_rst");
      rdchk(A_CFG, 8'h00, "cfg_rst");
      apb(1'b1, A_LAT, 8'h5A);
      apb(1'b1, A_DIR, 8'hCF);
      step(1);
      pchk("oe_dir", 8'hCF, pin_oe_n);
      pchk("out_dir", 8'h10, pin_out & 8'h30);
      rdchk(A_PIN, 8'h93, "pins");
      apb(1'b1, A_PIN, 8'h3C);
      rdchk(A_LAT, 8'h3C, "lat");
      // A write without the low byte lane must leave the latch alone.
      pstrb <= 4'hE;
      apb(1'b1, A_LAT, 8'h77);
      pstrb <= 4'hF;
      rdchk(A_LAT, 8'h3C, "lat_strb");
      apb(1'b1, A_NBR, 8'h80);
      @(posedge pclk);
      ext_en <= 1'b0;
      step(2);
      pchk("pu_on", 8'hCF, pullup_en);
      rdchk(A_PIN, 8'hFF, "pulled");
      apb(1'b1, A_NBR, 8'h00);
      step(1);
      pchk("pu_off", 8'h00, pullup_en);
      apb(1'b1, A_NBR, 8'h80);
      apb(1'b1, A_CFG, 8'h01);
      @(posedge pclk);
      ppa <= 1'b1;
      ppd <= 1'b1;
      ppdo <= 8'hA5;
      step(2);
      pchk("par_out", 8'hA5, pin_out);
      pchk("par_oe", 8'h00, pin_oe_n);
      pchk("par_ttl", 8'hFF, ttl_select);
      pchk("par_pu", 8'h00, pullup_en);
      @(posedge pclk);
      ppd <= 1'b0;
      ext_en <= 1'b1;
      ext_val <= 8'h96;
      step(2);
      pchk("par_in", 8'h96, pp_in);
      pchk("par_rel", 8'hFF, pin_oe_n);
      @(posedge pclk);
      ppd <= 1'b1;
      ext_en <= 1'b0;
      mbd <= 1'b1;
      muxed <= 8'hC3;
      apb(1'b1, A_MEM, 8'h00);
      step(1);
      chk("mem_en", 32'h1, {31'h0, mem_en});
      pchk("mem_out", 8'hC3, pin_out);
      pchk("mem_oe", 8'h00, pin_oe_n);
      @(posedge pclk);
      mbd <= 1'b0;
      ext_en <= 1'b1;
      ext_val <= 8'h69;
      step(2);
      pchk("mem_in", 8'h69, mem_rd);
      pchk("mem_ttl", 8'hFF, ttl_select);
      @(posedge pclk);
      ext_en <= 1'b0;
      apb(1'b1, A_MEM, 8'h80);
      step(1);
      pchk("par_back", 8'hA5, pin_out);
      apb(1'b1, A_CFG, 8'h00);
      step(1);
      pchk("cfg_off", 8'hCF, pin_oe_n);
      pchk("schmitt", 8'h00, ttl_select);
      apb(1'b1, 8'h18, 8'h55);
      chk("wr_err", 32'h1, {31'h0, err});
      rdchk(8'h18, 8'h00, "unmapped");
      rdchk(A_LAT, 8'h3C, "lat_kept");
      @(posedge pclk);
      presetn <= 1'b0;
      step(2);
      pchk("oe_rst2", 8'hFF, pin_oe_n);
      pchk("pu_rst2", 8'h00, pullup_en);
      @(posedge pclk);
      presetn <= 1'b1;
      rdchk(A_DIR, 8'hFF, "dir_rst2");
      wrap_up;
   end

   // Cuts a hang short well after the sequence should have ended.
   initial
   begin
      repeat (4000) @(posedge pclk);
      num_errors++;
      wrap_up;
   end
endmodule

bind mbpp_port mbpp_port_assertions i_mbpp_port_assertions (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .ttl_select(ttl_select),
   .muxed_addr_data_low(muxed_addr_data_low), .memory_bus_drive(memory_bus_drive),
   .memory_bus_read_data(memory_bus_read_data), .memory_bus_enabled(memory_bus_enabled),
   .parallel_port_active(parallel_port_active), .parallel_port_drive(parallel_port_drive));

/* File: verilog/mbpp_pin_owner.sv */
`timescale 1ns/10ps

// Steers the pin drivers, pull-ups and input thresholds from the current owner.
module mbpp_pin_owner
(
   // Ownership and port state.
   input wire mbpp_pkg::mbpp_owner_t owner,
   input wire logic [7:0] output_latch,
   input wire logic [7:0] direction_bits,
   input wire logic pullup_enable_bit,
   // External memory bus low byte.
   input wire logic [7:0] muxed_addr_data_low,
   input wire logic memory_bus_drive,
   // Parallel master port data.
   input wire logic [7:0] parallel_port_data_out,
   input wire logic parallel_port_drive,
   // Next pin controls.
   output logic [7:0] next_pin_out,
   output logic [7:0] next_pin_oe_n,
   output logic [7:0] next_pullup_en,
   output logic [7:0] next_ttl_select
);

   // The memory bus beats the parallel port, which beats the plain port.
   always_comb
   begin
      next_pin_out = output_latch;
      next_pin_oe_n = direction_bits;
      next_ttl_select = {8{mbpp_pkg::THRESHOLD_SCHMITT}};
      unique case (owner)
         mbpp_pkg::OWNER_MEMORY:
         begin
            // Direction comes from the bus cycle, the port direction is ignored.
            next_pin_out = muxed_addr_data_low;
            next_pin_oe_n = {8{~memory_bus_drive}};
            next_ttl_select = {8{mbpp_pkg::THRESHOLD_TTL}};
         end
         mbpp_pkg::OWNER_PARALLEL:
         begin
            next_pin_out = parallel_port_data_out;
            next_pin_oe_n = {8{~parallel_port_drive}};
            next_ttl_select = {8{mbpp_pkg::THRESHOLD_TTL}};
         end
         mbpp_pkg::OWNER_PORT:
         begin
            next_pin_out = output_latch;
            next_pin_oe_n = direction_bits;
            next_ttl_select = {8{mbpp_pkg::THRESHOLD_SCHMITT}};
         end
      endcase
      // A driven pin never keeps its pull-up, whatever the shared bit says.
      next_pullup_en = {8{pullup_enable_bit}} & next_pin_oe_n;
   end

endmodule

/* File: verilog/mbpp_pkg.sv */
package mbpp_pkg;

   // Register byte offsets on the APB slave.
   localparam logic [7:0] PIN_STATE_OFFSET = 8'h00;
   localparam logic [7:0] OUTPUT_LATCH_OFFSET = 8'h04;
   localparam logic [7:0] DIRECTION_OFFSET = 8'h08;
   localparam logic [7:0] MEMORY_BUS_CONTROL_OFFSET = 8'h0C;
   localparam logic [7:0] NEIGHBOUR_PORT_OFFSET = 8'h10;
   localparam logic [7:0] PARALLEL_CONFIG_OFFSET = 8'h14;

   // Field positions.
   localparam int BUS_INTERFACE_DISABLE_BIT = 7;
   localparam int PULLUP_ENABLE_BIT = 7;
   localparam int PARALLEL_PORT_PIN_SELECT_BIT = 0;

   // Port width.
   localparam int PORT_WIDTH = 8;

   // Reset values.
   localparam logic [7:0] OUTPUT_LATCH_RESET = 8'h00;
   localparam logic [7:0] DIRECTION_RESET = 8'hFF;
   localparam logic BUS_INTERFACE_DISABLE_RESET = 1'b1;
   localparam logic PULLUP_ENABLE_RESET = 1'b0;
   localparam logic PARALLEL_PORT_PIN_SELECT_RESET = 1'b0;
   localparam logic [7:0] PIN_OE_N_RESET = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Direction bit encodings.
   localparam logic DIR_OUTPUT = 1'b0;
   localparam logic DIR_INPUT = 1'b1;

   // Input buffer threshold select: 0 Schmitt trigger, 1 TTL.
   localparam logic THRESHOLD_SCHMITT = 1'b0;
   localparam logic THRESHOLD_TTL = 1'b1;

   // Which function owns the pins, highest priority last.
   typedef enum logic [1:0] {
      OWNER_PORT,
      OWNER_PARALLEL,
      OWNER_MEMORY
   } mbpp_owner_t;

endpackage

/* File: verilog/mbpp_port.sv */
`timescale 1ns/10ps

module mbpp_port
#(
   // Set for the larger package, which bonds out the external memory bus.
   parameter bit LARGE_PACKAGE = 1'b1
)
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port pins, split into input, output and output enable.
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_n,
   output logic [7:0] pullup_en,
   output logic [7:0] ttl_select,
   // External memory bus low byte.
   input wire logic [7:0] muxed_addr_data_low,
   input wire logic memory_bus_drive,
   output logic [7:0] memory_bus_read_data,
   output logic memory_bus_enabled,
   // Parallel master port data path.
   input wire logic parallel_port_active,
   input wire logic parallel_port_drive,
   input wire logic [7:0] parallel_port_data_out,
   output logic [7:0] parallel_port_data_in
);

   // Software-visible state.
   logic [7:0] output_latch;
   logic [7:0] direction_bits;
   logic [7:0] pin_state_register;
   logic bus_interface_disable;
   logic pullup_enable_bit;
   logic parallel_port_pin_select;

   // Bus decode and pin ownership.
   logic wr_access;
   logic rd_setup;
   logic low_lane;
   mbpp_pkg::mbpp_owner_t owner;
   logic [7:0] next_pin_out;
   logic [7:0] next_pin_oe_n;
   logic [7:0] next_pullup_en;
   logic [7:0] next_ttl_select;
   logic [31:0] next_prdata;

   // True for every offset that holds a register; used by decode and the error answer.
   function automatic logic offset_mapped(input logic [7:0] addr);
      begin
         offset_mapped = (addr == mbpp_pkg::PIN_STATE_OFFSET) ||
                         (addr == mbpp_pkg::OUTPUT_LATCH_OFFSET) ||
                         (addr == mbpp_pkg::DIRECTION_OFFSET) ||
                         (addr == mbpp_pkg::MEMORY_BUS_CONTROL_OFFSET) ||
                         (addr == mbpp_pkg::NEIGHBOUR_PORT_OFFSET) ||
                         (addr == mbpp_pkg::PARALLEL_CONFIG_OFFSET);
      end
   endfunction

   // The slave never inserts wait states, so every access completes in two cycles.
   assign pready = 1'b1;
   assign pslverr = psel && penable && !offset_mapped(paddr);
   assign wr_access = psel && penable && pwrite && offset_mapped(paddr);
   assign rd_setup = psel && !penable && !pwrite;
   // Registers are a byte wide, so only the lowest lane carries them.
   assign low_lane = pstrb[0];

   // The memory bus exists only on the larger package and only while not disabled.
   assign memory_bus_enabled = LARGE_PACKAGE && !bus_interface_disable;

   // Priority: memory bus, then the parallel port when routed here, then the port.
   always_comb
   begin
      if (memory_bus_enabled)
      begin
         owner = mbpp_pkg::OWNER_MEMORY;
      end
      else if (parallel_port_active && parallel_port_pin_select)
      begin
         owner = mbpp_pkg::OWNER_PARALLEL;
      end
      else
      begin
         owner = mbpp_pkg::OWNER_PORT;
      end
   end

   // Pin control steering for the current owner.
   mbpp_pin_owner i_mbpp_pin_owner
   (
      .owner(owner),
      .output_latch(output_latch),
      .direction_bits(direction_bits),
      .pullup_enable_bit(pullup_enable_bit),
      .muxed_addr_data_low(muxed_addr_data_low),
      .memory_bus_drive(memory_bus_drive),
      .parallel_port_data_out(parallel_port_data_out),
      .parallel_port_drive(parallel_port_drive),
      .next_pin_out(next_pin_out),
      .next_pin_oe_n(next_pin_oe_n),
      .next_pullup_en(next_pullup_en),
      .next_ttl_select(next_ttl_select)
   );

   // Output latch: a write to either the value or the latch offset lands here.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         output_latch <= mbpp_pkg::OUTPUT_LATCH_RESET;
      end
      else if (wr_access && low_lane &&
               ((paddr == mbpp_pkg::PIN_STATE_OFFSET) ||
                (paddr == mbpp_pkg::OUTPUT_LATCH_OFFSET)))
      begin
         output_latch <= pwdata[7:0];
      end
   end

   // Direction bits come up all ones so no pin drives after reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         direction_bits <= mbpp_pkg::DIRECTION_RESET;
      end
      else if (wr_access && low_lane && (paddr == mbpp_pkg::DIRECTION_OFFSET))
      begin
         direction_bits <= pwdata[7:0];
      end
   end

   // Memory bus control. It resets disabled so the port pins start as inputs.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_interface_disable <= mbpp_pkg::BUS_INTERFACE_DISABLE_RESET;
      end
      else if (wr_access && low_lane && (paddr == mbpp_pkg::MEMORY_BUS_CONTROL_OFFSET))
      begin
         bus_interface_disable <= pwdata[mbpp_pkg::BUS_INTERFACE_DISABLE_BIT];
      end
   end

   // Shared pull-up control living in the neighbouring port register.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pullup_enable_bit <= mbpp_pkg::PULLUP_ENABLE_RESET;
      end
      else if (wr_access && low_lane && (paddr == mbpp_pkg::NEIGHBOUR_PORT_OFFSET))
      begin
         pullup_enable_bit <= pwdata[mbpp_pkg::PULLUP_ENABLE_BIT];
      end
   end

   // Parallel port routing select.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         parallel_port_pin_select <= mbpp_pkg::PARALLEL_PORT_PIN_SELECT_RESET;
      end
      else if (wr_access && low_lane && (paddr == mbpp_pkg::PARALLEL_CONFIG_OFFSET))
      begin
         parallel_port_pin_select <= pwdata[mbpp_pkg::PARALLEL_PORT_PIN_SELECT_BIT];
      end
   end

   // Pin drivers are registered so the pads never see decode glitches.
   // The cost is one cycle from a bus request or register write to the pad.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_out <= mbpp_pkg::BYTE_ZERO;
         pin_oe_n <= mbpp_pkg::PIN_OE_N_RESET;
         pullup_en <= mbpp_pkg::BYTE_ZERO;
         ttl_select <= {8{mbpp_pkg::THRESHOLD_SCHMITT}};
      end
      else
      begin
         pin_out <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
         pullup_en <= next_pullup_en;
         ttl_select <= next_ttl_select;
      end
   end

   // Pin sampling. The pad applies the threshold chosen above before this flop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_state_register <= mbpp_pkg::BYTE_ZERO;
      end
      else
      begin
         pin_state_register <= pin_in;
      end
   end

   // Incoming data for the memory bus and the parallel port, captured only while owned and not driving, held otherwise.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         memory_bus_read_data <= mbpp_pkg::BYTE_ZERO;
         parallel_port_data_in <= mbpp_pkg::BYTE_ZERO;
      end
      else
      begin
         if (owner == mbpp_pkg::OWNER_MEMORY && !memory_bus_drive)
         begin
            memory_bus_read_data <= pin_in;
         end
         if (owner == mbpp_pkg::OWNER_PARALLEL && !parallel_port_drive)
         begin
            parallel_port_data_in <= pin_in;
         end
      end
   end

   // Read mux. Reserved bits and unmapped offsets read as zero.
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         mbpp_pkg::PIN_STATE_OFFSET:
         begin
            next_prdata[7:0] = pin_state_register;
         end
         mbpp_pkg::OUTPUT_LATCH_OFFSET:
         begin
            next_prdata[7:0] = output_latch;
         end
         mbpp_pkg::DIRECTION_OFFSET:
         begin
            next_prdata[7:0] = direction_bits;
         end
         mbpp_pkg::MEMORY_BUS_CONTROL_OFFSET:
         begin
            next_prdata[mbpp_pkg::BUS_INTERFACE_DISABLE_BIT] = bus_interface_disable;
         end
         mbpp_pkg::NEIGHBOUR_PORT_OFFSET:
         begin
            next_prdata[mbpp_pkg::PULLUP_ENABLE_BIT] = pullup_enable_bit;
         end
         mbpp_pkg::PARALLEL_CONFIG_OFFSET:
         begin
            next_prdata[mbpp_pkg::PARALLEL_PORT_PIN_SELECT_BIT] = parallel_port_pin_select;
         end
         default:
         begin
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   // Read data is captured in the setup cycle and stands through the access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (rd_setup)
      begin
         prdata <= next_prdata;
      end
   end

endmodule
